/* File: core/elu_line_unit.sv */
// external line event unit: edge capture, pending flags and axi4-lite registers
`timescale 1ns/100ps
module elu_line_unit #(
  parameter int NUM_PINS = elu_pkg::NUM_GP_PINS
) (
  // clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // axi4-lite write address and data
  input  wire logic [elu_pkg::ADDR_W-1:0]        awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  // axi4-lite write response
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  // axi4-lite read
  input  wire logic [elu_pkg::ADDR_W-1:0]        araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // line sources
  input  wire logic [NUM_PINS-1:0]               gp_pins,
  input  wire logic                              supply_threshold_detector,
  input  wire logic                              clock_alarm,
  input  wire logic                              spare_line,
  // requests
  output logic [elu_pkg::NUM_LINES-1:0]          line_irq,
  output logic [elu_pkg::NUM_LINES-1:0]          line_evt,
  output logic                                   irq,
  output logic                                   wake_req
);
  import elu_pkg::*;

  if (NUM_PINS < 1 || NUM_PINS > (1 << SEL_W)) begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and 128");
  end
  // the edge compare reads the last two stages, so one stage must sit in front of them
  if (SYNC_DEPTH < 3) begin : g_bad_sync
    $error("SYNC_DEPTH must be at least 3");
  end
  if (NUM_SEL_REGS * SEL_PER_REG != NUM_PIN_LINES) begin : g_bad_sel
    $error("selector words must cover every pin line");
  end

  function automatic elu_reg_e reg_index(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_IRQ_MASK: reg_index = ELU_R_IRQ_MASK;
      OFS_EVT_MASK: reg_index = ELU_R_EVT_MASK;
      OFS_RISE_SEL: reg_index = ELU_R_RISE;
      OFS_FALL_SEL: reg_index = ELU_R_FALL;
      OFS_PENDING:  reg_index = ELU_R_PENDING;
      OFS_PIN_SEL0: reg_index = ELU_R_SEL0;
      OFS_PIN_SEL0 + 8'h04: reg_index = ELU_R_SEL1;
      OFS_PIN_SEL0 + 8'h08: reg_index = ELU_R_SEL2;
      OFS_PIN_SEL0 + 8'h0C: reg_index = ELU_R_SEL3;
      default:      reg_index = ELU_R_NONE;
    endcase
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // configuration and state
  logic [NUM_LINES-1:0] irq_mask;
  logic [NUM_LINES-1:0] evt_mask;
  logic [NUM_LINES-1:0] rise_sel;
  logic [NUM_LINES-1:0] fall_sel;
  logic [NUM_LINES-1:0] pending;
  logic [SEL_W-1:0]     pin_sel [NUM_PIN_LINES];

  // write channel holding state
  logic                 aw_held;
  logic                 w_held;
  logic [ADDR_W-1:0]    awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 next_aw_held;
  logic                 next_w_held;
  logic                 do_write;
  logic                 next_rvalid;
  elu_reg_e             wr_idx;
  logic [31:0]          wr_mask;

  wire  [NUM_LINES-1:0] line_src;
  wire  [NUM_LINES-1:0] rise_hit;
  wire  [NUM_LINES-1:0] fall_hit;
  logic [NUM_LINES-1:0] trig;
  logic [NUM_LINES-1:0] clr;
  logic [NUM_LINES-1:0] next_pending;

  // one selector word: four fields, one to a byte lane, top bit of each lane reads 0
  function automatic logic [31:0] sel_word(input int r);
    sel_word = '0;
    for (int j = 0; j < SEL_PER_REG; j++) begin
      sel_word[j*8 +: SEL_W] = pin_sel[r*SEL_PER_REG + j];
    end
  endfunction

  // line sources: pin selectors, then dedicated lines
  // changing a selector may glitch its line; mask the line while reprogramming
  for (genvar i = 0; i < NUM_PIN_LINES; i++) begin : g_pin_mux
    assign line_src[i] = (32'(pin_sel[i]) < NUM_PINS) ? gp_pins[pin_sel[i]] : 1'b0;
  end
  assign line_src[LINE_SUPPLY] = supply_threshold_detector;
  assign line_src[LINE_ALARM]  = clock_alarm;
  assign line_src[LINE_SPARE]  = spare_line;

  // per-line capture: toggles clocked by the line itself hold an edge of any width,
  // even with aclk stopped, and the toggle state crosses by a plain synchroniser
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    logic                  rise_tgl = 1'b0;
    logic                  fall_tgl = 1'b0;
    logic [SYNC_DEPTH-1:0] rise_sync = '0;
    logic [SYNC_DEPTH-1:0] fall_sync = '0;

    always_ff @(posedge line_src[i]) begin
      rise_tgl <= ~rise_tgl;
    end

    always_ff @(negedge line_src[i]) begin
      fall_tgl <= ~fall_tgl;
    end

    // no reset here: a reset must not fake a toggle difference
    always_ff @(posedge aclk) begin
      rise_sync <= {rise_sync[SYNC_DEPTH-2:0], rise_tgl};
      fall_sync <= {fall_sync[SYNC_DEPTH-2:0], fall_tgl};
    end

    assign rise_hit[i] = rise_sync[SYNC_DEPTH-1] ^ rise_sync[SYNC_DEPTH-2];
    assign fall_hit[i] = fall_sync[SYNC_DEPTH-1] ^ fall_sync[SYNC_DEPTH-2];
  end

  // trigger selection per line; on the supply line fall/rise mean below/above threshold
  always_comb begin
    trig = (rise_hit & rise_sel) | (fall_hit & fall_sel);
  end

  // write channel: address and data are taken in either order, one write at a time
  // a held write waits while an earlier response is still untaken
  always_comb begin
    do_write     = aw_held && w_held && !bvalid;
    next_aw_held = (aw_held && !do_write) || (awvalid && awready);
    next_w_held  = (w_held && !do_write) || (wvalid && wready);
    next_rvalid  = (arvalid && arready) || (rvalid && !rready);
    wr_idx       = reg_index(awaddr_q);
    wr_mask      = lane_mask(wstrb_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held;
      wready  <= !next_w_held;
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= (wr_idx == ELU_R_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= RST_LINES;
      evt_mask <= RST_LINES;
      rise_sel <= RST_LINES;
      fall_sel <= RST_LINES;
    end else if (do_write) begin
      case (wr_idx)
        ELU_R_IRQ_MASK: begin
          irq_mask <= (irq_mask & ~wr_mask[NUM_LINES-1:0]) |
                      (wdata_q[NUM_LINES-1:0] & wr_mask[NUM_LINES-1:0]);
        end
        ELU_R_EVT_MASK: begin
          evt_mask <= (evt_mask & ~wr_mask[NUM_LINES-1:0]) |
                      (wdata_q[NUM_LINES-1:0] & wr_mask[NUM_LINES-1:0]);
        end
        ELU_R_RISE: begin
          rise_sel <= (rise_sel & ~wr_mask[NUM_LINES-1:0]) |
                      (wdata_q[NUM_LINES-1:0] & wr_mask[NUM_LINES-1:0]);
        end
        ELU_R_FALL: begin
          fall_sel <= (fall_sel & ~wr_mask[NUM_LINES-1:0]) |
                      (wdata_q[NUM_LINES-1:0] & wr_mask[NUM_LINES-1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // pin selectors: one byte lane per line, four lines to a word
  for (genvar i = 0; i < NUM_PIN_LINES; i++) begin : g_sel_reg
    localparam int REG  = i / SEL_PER_REG;
    localparam int LANE = i % SEL_PER_REG;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_sel[i] <= RST_SEL;
      end else if (do_write && wr_idx == elu_reg_e'(4'(int'(ELU_R_SEL0) + REG)) &&
                   wstrb_q[LANE]) begin
        pin_sel[i] <= wdata_q[LANE*8 +: SEL_W];
      end
    end
  end

  // pending flags: write one clears, a trigger in the same cycle wins
  // masks gate the outputs only, so software can still poll a masked line
  always_comb begin
    clr = '0;
    if (do_write && wr_idx == ELU_R_PENDING) begin
      clr = wdata_q[NUM_LINES-1:0] & wr_mask[NUM_LINES-1:0];
    end
    next_pending = (pending & ~clr) | trig;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= RST_LINES;
    end else begin
      pending <= next_pending;
    end
  end

  // requests to the core and the power controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_irq <= RST_LINES;
      line_evt <= RST_LINES;
      irq      <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      line_irq <= next_pending & irq_mask;
      line_evt <= trig & evt_mask;
      irq      <= |(next_pending & irq_mask);
      wake_req <= |(next_pending & irq_mask) | |(trig & evt_mask);
    end
  end

  // read channel: answer one cycle after the address is taken
  // rdata shows the registers as they stood at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (arvalid && arready) begin
        rresp <= RESP_OKAY;
        rdata <= '0;
        case (reg_index(araddr))
          ELU_R_IRQ_MASK: rdata[NUM_LINES-1:0] <= irq_mask;
          ELU_R_EVT_MASK: rdata[NUM_LINES-1:0] <= evt_mask;
          ELU_R_RISE:     rdata[NUM_LINES-1:0] <= rise_sel;
          ELU_R_FALL:     rdata[NUM_LINES-1:0] <= fall_sel;
          ELU_R_PENDING:  rdata[NUM_LINES-1:0] <= pending;
          ELU_R_SEL0:     rdata <= sel_word(0);
          ELU_R_SEL1:     rdata <= sel_word(1);
          ELU_R_SEL2:     rdata <= sel_word(2);
          ELU_R_SEL3:     rdata <= sel_word(3);
          default:        rresp <= RESP_SLVERR;
        endcase
      end
    end
  end

endmodule

/* File: core/elu_pkg.sv */
// constants, register map and field layout of the external line event unit
// Contract
// - the unit has nineteen edge-detector lines, each able to raise an interrupt or an event.
// - each line selects rising, falling or both edges as its trigger, independently of the others.
// - each line has its own mask, and a masked line forwards nothing without touching other lines.
// - every detected trigger sets a pending flag that software reads to see which line asked.
// - an input pulse narrower than one bus clock period is caught by asynchronous capture.
// - sixteen lines each take one of up to eighty general pins through a selector.
// - the supply threshold detector output and the clock alarm each have a line of their own.
// - a trigger is caught while the bus clock is halted in Stop mode and wakes the device; the code registers wake_req on aclk, so it rises only once aclk runs.
// - in Sleep mode an interrupt or event request from the unit wakes the processor.
// - the supply detector line can interrupt on falling, rising or both threshold crossings.
package elu_pkg;
  localparam int NUM_LINES     = 19;
  localparam int NUM_PIN_LINES = 16;
  localparam int NUM_GP_PINS   = 80;
  localparam int SEL_W         = 7;
  localparam int SEL_PER_REG   = 4;
  localparam int NUM_SEL_REGS  = NUM_PIN_LINES / SEL_PER_REG;
  localparam int LINE_SUPPLY   = 16;
  localparam int LINE_ALARM    = 17;
  localparam int LINE_SPARE    = 18;
  localparam int SYNC_DEPTH    = 3;
  localparam int ADDR_W        = 8;

  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RISE_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FALL_SEL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PENDING  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PIN_SEL0 = 8'h20;

  localparam logic [NUM_LINES-1:0] RST_LINES = 19'h0_0000;
  localparam logic [SEL_W-1:0]     RST_SEL   = 7'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ELU_R_IRQ_MASK = 4'h0,
    ELU_R_EVT_MASK = 4'h1,
    ELU_R_RISE     = 4'h2,
    ELU_R_FALL     = 4'h3,
    ELU_R_PENDING  = 4'h4,
    ELU_R_SEL0     = 4'h5,
    ELU_R_SEL1     = 4'h6,
    ELU_R_SEL2     = 4'h7,
    ELU_R_SEL3     = 4'h8,
    ELU_R_NONE     = 4'hF
  } elu_reg_e;
endpackage

/* File: tb/elu_line_unit_asserts.sv */
// concurrent checks on the external line event unit ports
`timescale 1ns/100ps
module elu_line_unit_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  // requests
  input wire logic [18:0] line_irq,
  input wire logic [18:0] line_evt,
  input wire logic        irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_pair;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  a_irq_any_line: assert property (irq == (|line_irq))
    else $error("irq differs from line requests");
  a_evt_single: assert property (|line_evt |=> (line_evt & $past(line_evt)) == '0)
    else $error("event pulse longer than one cycle");
  a_wake_on_req: assert property ((irq || |line_evt) |-> wake_req)
    else $error("request without wake");
  // a line request may only drop as a write lands
  a_irq_hold: assert property (|(~line_irq & $past(line_irq)) |-> $rose(bvalid) || $fell(bvalid))
    else $error("line request dropped without a write");
  a_aw_refuse: assert property (s_wr_pair |=> !awready && !wready)
    else $error("write channels still ready");
  a_wr_answer: assert property (s_wr_pair |-> ##2 bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_take |=> rvalid)
    else $error("read response late");
  a_rd_block: assert property (rvalid |-> !arready)
    else $error("read address taken during response");
endmodule

/* File: tb/elu_line_src.sv */
// line sources: general pins, supply detector, clock alarm, spare input
`timescale 1ns/100ps
module elu_line_src (
  // line sources
  output logic [79:0] gp_pins,
  output logic        sup,
  output logic        alm,
  output logic        spr
);
  // supply idles above threshold, the others idle low
  initial {gp_pins, sup, alm, spr} = {80'h0, 3'h4};
  // source 0..79 pin, 80 supply, 81 alarm, 82 spare; w may be under one cycle
  task automatic pulse(input int s, input int w);
    repeat (2) begin
      if (s < 80) gp_pins[s] = ~gp_pins[s];
      else if (s == 80) sup = ~sup;
      else if (s == 81) alm = ~alm;
      else spr = ~spr;
      #(w);
    end
  endtask
endmodule

/* File: tb/tb_external_line_event_unit.sv */
// self-checking bench for the external line event unit
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_external_line_event_unit;
  import elu_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sup, alm, spr;
  logic        awready, wready, bvalid, arready, rvalid, irq, wake_req, run = 1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, bx;
  logic [79:0] gp_pins;
  logic [18:0] line_irq, line_evt;
  logic [33:0] rx;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [7:0]  ofs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2C};
  int          err_count, checked, pin, evt_cnt[19], seed = 32'h13e9_e3d7;
  elu_line_unit dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .gp_pins, .supply_threshold_detector(sup), .clock_alarm(alm), .spare_line(spr),
    .line_irq, .line_evt, .irq, .wake_req);
  elu_line_src src (.gp_pins, .sup, .alm, .spr);
  initial begin
    aclk = 0;
    forever #5 if (run) aclk = ~aclk;
  end
  initial begin
    #100us;
    err_count++;
    close_out();
  end
  task automatic close_out();
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
  endtask
  // responses are matched in arrival order against the driver's notes
  always @(posedge aclk) begin
    for (int k = 0; k < 19; k++) evt_cnt[k] += line_evt[k];
    if (bvalid && bready) begin
      bx = bq.pop_front();
      `CHK("bresp", bx, bresp)
    end
    if (rvalid && rready) begin
      rx = rq.pop_front();
      `CHK("read", rx, {rresp, rdata})
    end
  end
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    bready = 1; rready = 1; aresetn = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    foreach (ofs[i]) rd(ofs[i], '0);
    rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h40, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    wr(OFS_IRQ_MASK, 32'h0007_FFFF, 4'hF, RESP_OKAY);
    wr(OFS_EVT_MASK, 32'h0007_FFFF, 4'hF, RESP_OKAY);
    wr(OFS_RISE_SEL, 32'h0007_FFFF, 4'hF, RESP_OKAY);
    for (int k = 0; k < 19; k++) begin
      // distinct pins per line, never pin 0, where unprogrammed selectors still point
      pin = k < 16 ? 5 * k + 1 + $unsigned($random(seed)) % 4 : 64 + k;
      if (k < 16) wr(8'(OFS_PIN_SEL0 + 4 * (k / 4)), 32'(pin << (8 * (k % 4))),
                     4'(1 << (k % 4)), RESP_OKAY);
      #3 src.pulse(pin, 3);
      repeat (6) @(posedge aclk);
      `CHK("line_irq", 19'(1 << k), line_irq)
      `CHK("wake_req", 1'b1, wake_req)
      rd(OFS_PENDING, {RESP_OKAY, 32'(1 << k)});
      wr(OFS_PENDING, 32'h0000_0000, 4'hF, RESP_OKAY);
      rd(OFS_PENDING, {RESP_OKAY, 32'(1 << k)});
      wr(OFS_PENDING, 32'(1 << k), 4'hF, RESP_OKAY);
      `CHK("irq", 1'b0, irq)
    end
    for (int k = 0; k < 19; k++) `CHK("evt_cnt", 1, evt_cnt[k])
    wr(OFS_RISE_SEL, 32'h0000_0000, 4'hF, RESP_OKAY);
    wr(OFS_FALL_SEL, 32'h0007_0000, 4'hF, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h0005_FFFF, 4'hF, RESP_OKAY);
    #3 src.pulse(80, 50);
    src.pulse(81, 50);
    repeat (6) @(posedge aclk);
    `CHK("line_irq", 19'h1_0000, line_irq)
    rd(OFS_PENDING, {RESP_OKAY, 32'h0003_0000});
    wr(OFS_PENDING, 32'h0007_FFFF, 4'hF, RESP_OKAY);
    // supply line on both edges: one event per crossing
    wr(OFS_RISE_SEL, 32'h0001_0000, 4'hF, RESP_OKAY);
    #3 src.pulse(80, 50);
    repeat (6) @(posedge aclk);
    `CHK("evt_cnt", 4, evt_cnt[16])
    rd(OFS_PENDING, {RESP_OKAY, 32'h0001_0000});
    wr(OFS_PENDING, 32'h0001_0000, 4'hF, RESP_OKAY);
    // bus clock halted while the spare line pulses
    #2 run = 0;
    src.pulse(82, 2);
    #100 run = 1;
    repeat (6) @(posedge aclk);
    rd(OFS_PENDING, {RESP_OKAY, 32'h0004_0000});
    repeat (2) @(posedge aclk);
    close_out();
  end
endmodule
bind elu_line_unit elu_line_unit_asserts chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .arvalid, .arready, .rvalid, .line_irq, .line_evt, .irq, .wake_req);
